// file: spsr_pkg.sv
package spsr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TOL_W  = 21;
  localparam int unsigned BW_W   = 7;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] ADDR_LOOP_TOL  = 12'hC06;
  localparam logic [ADDR_W-1:0] ADDR_START     = 12'hC07;
  localparam logic [ADDR_W-1:0] ADDR_RESET     = 12'hC08;
  localparam logic [ADDR_W-1:0] ADDR_NV_STAT   = 12'hD00;
  localparam logic [ADDR_W-1:0] ADDR_CLK_STAT  = 12'hD01;
  localparam logic [ADDR_W-1:0] ADDR_STAT_LAST = 12'hD14;

  localparam int unsigned TRIG_BIT = 0;
  localparam int unsigned CFG_W    = 5;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  // loop bandwidth codes
  localparam logic [1:0] BW_50HZ  = 2'h0;
  localparam logic [1:0] BW_1HZ   = 2'h1;
  localparam logic [1:0] BW_10HZ  = 2'h2;
  localparam logic [1:0] BW_100HZ = 2'h3;
  localparam logic [BW_W-1:0] BW_VAL_50  = 7'h32;
  localparam logic [BW_W-1:0] BW_VAL_1   = 7'h01;
  localparam logic [BW_W-1:0] BW_VAL_10  = 7'h0A;
  localparam logic [BW_W-1:0] BW_VAL_100 = 7'h64;

  // tolerance codes; limits in units of 0.1 ppm
  localparam logic [1:0] TOL_GENERAL = 2'h0;
  localparam logic [1:0] TOL_STRAT3  = 2'h1;
  localparam logic [1:0] TOL_SMC     = 2'h2;
  localparam logic [1:0] TOL_XTAL    = 2'h3;
  localparam logic [TOL_W-1:0] TOL_OUT_GENERAL = 21'h0F4240; // 10 %
  localparam logic [TOL_W-1:0] TOL_IN_GENERAL  = 21'h0C3500; // 8 %
  localparam logic [TOL_W-1:0] TOL_OUT_STRAT3  = 21'h000078; // 12 ppm
  localparam logic [TOL_W-1:0] TOL_IN_STRAT3   = 21'h000060; // 9.6 ppm
  localparam logic [TOL_W-1:0] TOL_OUT_SMC     = 21'h0001E0; // 48 ppm
  localparam logic [TOL_W-1:0] TOL_IN_SMC      = 21'h00017C; // 38 ppm
  localparam logic [TOL_W-1:0] TOL_OUT_XTAL    = 21'h0007D0; // 200 ppm
  localparam logic [TOL_W-1:0] TOL_IN_XTAL     = 21'h000640; // 160 ppm

  typedef struct packed {
    logic       high_phase_margin;
    logic [1:0] loop_bw;
    logic [1:0] tolerance;
  } spsr_cfg_type;

  localparam spsr_cfg_type CFG_RESET = '{1'b0, BW_50HZ, TOL_GENERAL};

  typedef struct packed {
    logic pin_rom_read;
    logic eeprom_fault;
    logic eeprom_load;
    logic eeprom_save;
  } spsr_nv_status_type;

  typedef struct packed {
    logic raw_sys_lock;
    logic vco_ok;
    logic cal_busy;
    logic analog_lock;
    logic digital_lock;
    logic sys_stable;
    logic gated_sys_lock;
  } spsr_clk_status_type;

  typedef enum logic {SPSR_IDLE, SPSR_BUSY} spsr_state_type;

endpackage

// file: spsr_soft_pin_status.sv
// Summary of operation
// - digital_loop bandwidth code 00=50 Hz, 01=1 Hz, 10=10 Hz, 11=100 Hz.
// - tolerance code 00 gives 10%/8%, code 01 gives 12/9.6 ppm.
// - tolerance code 10 gives 48/38 ppm, code 11 gives 200/160 ppm.
// - start trigger launches ROM download without reset, clears when download finishes.
// - soft-pin reset trigger resets device, launches download, keeps map, self-clears.
// - soft-pin settings only take effect at a start or soft-pin reset trigger.
// - status range is read only; writes there change nothing.
// - the first two status registers show live values on every read.
// - nonvolatile status bit 3 set while pin-program ROM is read.
// - nonvolatile status bit 2 flags an EEPROM save or load error.
// - nonvolatile status bit 1 held set while EEPROM is read.
// - nonvolatile status bit 0 held set while EEPROM is written.
// - clock status bit 7 is the raw system_clock_multiplier lock.
// - clock status bit 6 is combined_loop_lock_flag: digital and analog loops locked.
// - clock status bit 5 set only when all three loops are locked.
// - clock status bit 4 shows the output_analog_loop loop_oscillator running properly.
// - clock status bit 3 set while loop_oscillator amplitude calibration runs.
// - clock status bit 2 is output_analog_loop lock.
// - clock status bit 1 set only after the stability timer expired.
// - clock status bit 0 is the gated system_clock_multiplier lock.
`timescale 1ns/10ps
`default_nettype none

module spsr_soft_pin_status (
  input  wire logic                        ref_clk_in,             // 50 MHz system clock
  input  wire logic                        rst_in,                 // sync reset, active high
  input  wire logic [spsr_pkg::ADDR_W-1:0] addr_in,                // register address
  input  wire logic [spsr_pkg::DATA_W-1:0] wr_data_in,             // write data
  input  wire logic                        wr_stb_in,              // write strobe
  input  wire logic                        rd_stb_in,              // read strobe
  output logic      [spsr_pkg::DATA_W-1:0] rd_data_out,            // read data, next cycle
  input  wire spsr_pkg::spsr_nv_status_type  nv_status_in,         // eeprom/rom activity
  input  wire spsr_pkg::spsr_clk_status_type clk_status_in,        // loop lock states
  input  wire logic                        rom_download_done_in,   // download finished pulse
  output logic                             rom_download_start_out, // launch download pulse
  output logic                             device_soft_reset_out,  // device reset pulse
  output spsr_pkg::spsr_cfg_type           applied_cfg_out,        // settings in effect
  output logic      [spsr_pkg::BW_W-1:0]   loop_bw_hz_out,         // bandwidth in Hz
  output logic      [spsr_pkg::TOL_W-1:0]  outer_tol_out,          // outer limit, 0.1 ppm
  output logic      [spsr_pkg::TOL_W-1:0]  inner_tol_out           // inner limit, 0.1 ppm
);
  import spsr_pkg::*;

  function automatic logic [BW_W-1:0] bw_hz(input logic [1:0] code);
    case (code)
      BW_1HZ:   bw_hz = BW_VAL_1;
      BW_10HZ:  bw_hz = BW_VAL_10;
      BW_100HZ: bw_hz = BW_VAL_100;
      default:  bw_hz = BW_VAL_50;
    endcase
  endfunction

  function automatic logic [TOL_W-1:0] tol_outer(input logic [1:0] code);
    case (code)
      TOL_STRAT3: tol_outer = TOL_OUT_STRAT3;
      TOL_SMC:    tol_outer = TOL_OUT_SMC;
      TOL_XTAL:   tol_outer = TOL_OUT_XTAL;
      default:    tol_outer = TOL_OUT_GENERAL;
    endcase
  endfunction

  function automatic logic [TOL_W-1:0] tol_inner(input logic [1:0] code);
    case (code)
      TOL_STRAT3: tol_inner = TOL_IN_STRAT3;
      TOL_SMC:    tol_inner = TOL_IN_SMC;
      TOL_XTAL:   tol_inner = TOL_IN_XTAL;
      default:    tol_inner = TOL_IN_GENERAL;
    endcase
  endfunction

  spsr_state_type state;
  spsr_state_type next_state;
  spsr_cfg_type   cfg;
  logic           start_bit;
  logic           reset_bit;

  wire logic hit_cfg   = addr_in == ADDR_LOOP_TOL;
  wire logic hit_start = addr_in == ADDR_START;
  wire logic hit_reset = addr_in == ADDR_RESET;
  wire logic hit_nv    = addr_in == ADDR_NV_STAT;
  wire logic hit_clk   = addr_in == ADDR_CLK_STAT;

  // status range has no write path at all
  wire logic wr_cfg    = wr_stb_in && hit_cfg;
  wire logic idle      = state == SPSR_IDLE;
  wire logic trig_start = wr_stb_in && hit_start && wr_data_in[TRIG_BIT] && idle;
  wire logic trig_reset = wr_stb_in && hit_reset && wr_data_in[TRIG_BIT] && idle;
  wire logic trig_any   = trig_start || trig_reset;
  wire logic finished   = (state == SPSR_BUSY) && rom_download_done_in;

  wire logic [DATA_W-1:0] nv_byte = {4'h0,
                                     nv_status_in.pin_rom_read,
                                     nv_status_in.eeprom_fault,
                                     nv_status_in.eeprom_load,
                                     nv_status_in.eeprom_save};

  wire logic loops_locked = clk_status_in.digital_lock && clk_status_in.analog_lock;

  wire logic [DATA_W-1:0] clk_byte = {clk_status_in.raw_sys_lock,
                                      loops_locked,
                                      loops_locked && clk_status_in.raw_sys_lock,
                                      clk_status_in.vco_ok,
                                      clk_status_in.cal_busy,
                                      clk_status_in.analog_lock,
                                      clk_status_in.sys_stable,
                                      clk_status_in.gated_sys_lock};

  // live status, reserved bits and unmapped addresses read zero
  wire logic [DATA_W-1:0] next_rd_data =
    hit_cfg   ? {3'h0, cfg} :
    hit_start ? {7'h00, start_bit} :
    hit_reset ? {7'h00, reset_bit} :
    hit_nv    ? nv_byte :
    hit_clk   ? clk_byte :
    ZERO_BYTE;

  always_comb begin
    next_state = state;
    case (state)
      SPSR_IDLE: begin
        if (trig_any) begin
          next_state = SPSR_BUSY;
        end
      end
      SPSR_BUSY: begin
        if (rom_download_done_in) begin
          next_state = SPSR_IDLE;
        end
      end
      default: next_state = SPSR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state       <= SPSR_IDLE;
      cfg         <= CFG_RESET;
      rd_data_out <= ZERO_BYTE;
    end else begin
      state       <= next_state;
      rd_data_out <= rd_stb_in ? next_rd_data : ZERO_BYTE;
      if (wr_cfg) begin
        cfg <= spsr_cfg_type'(wr_data_in[CFG_W-1:0]);
      end
    end
  end

  // triggers: set on launch, cleared by download completion
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      start_bit              <= 1'b0;
      reset_bit              <= 1'b0;
      rom_download_start_out <= 1'b0;
      device_soft_reset_out  <= 1'b0;
    end else begin
      rom_download_start_out <= trig_any;
      device_soft_reset_out  <= trig_reset;
      if (trig_start) begin
        start_bit <= 1'b1;
      end else if (finished) begin
        start_bit <= 1'b0;
      end
      if (trig_reset) begin
        reset_bit <= 1'b1;
      end else if (finished) begin
        reset_bit <= 1'b0;
      end
    end
  end

  // settings applied only at a trigger
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      applied_cfg_out <= CFG_RESET;
      loop_bw_hz_out  <= BW_VAL_50;
      outer_tol_out   <= TOL_OUT_GENERAL;
      inner_tol_out   <= TOL_IN_GENERAL;
    end else if (trig_any) begin
      applied_cfg_out <= cfg;
      loop_bw_hz_out  <= bw_hz(cfg.loop_bw);
      outer_tol_out   <= tol_outer(cfg.tolerance);
      inner_tol_out   <= tol_inner(cfg.tolerance);
    end
  end

endmodule

`default_nettype wire

// file: spsr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module spsr_monitor
  import spsr_pkg::*;
(
  input wire logic                ref_clk_in,             // clk
  input wire logic                rst_in,                 // rst
  input wire logic [ADDR_W-1:0]   addr_in,                // addr
  input wire logic [DATA_W-1:0]   wr_data_in,             // wdata
  input wire logic                wr_stb_in,              // wr
  input wire logic                rd_stb_in,              // rd
  input wire logic [DATA_W-1:0]   rd_data_out,            // rdata
  input wire spsr_nv_status_type  nv_status_in,           // nv
  input wire spsr_clk_status_type clk_status_in,          // locks
  input wire logic                rom_download_start_out, // start
  input wire logic                device_soft_reset_out,  // sreset
  input wire spsr_cfg_type        applied_cfg_out,        // cfg
  input wire logic [BW_W-1:0]     loop_bw_hz_out,         // bw
  input wire logic [TOL_W-1:0]    outer_tol_out,          // outer
  input wire logic [TOL_W-1:0]    inner_tol_out           // inner
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [DATA_W-1:0] clk_exp;
  logic [1:0]        t;
  logic [1:0]        b;
  assign t = applied_cfg_out.tolerance;
  assign b = applied_cfg_out.loop_bw;
  assign clk_exp = {clk_status_in.raw_sys_lock,
    clk_status_in.digital_lock & clk_status_in.analog_lock,
    clk_status_in.raw_sys_lock & clk_status_in.digital_lock & clk_status_in.analog_lock,
    clk_status_in.vco_ok, clk_status_in.cal_busy, clk_status_in.analog_lock,
    clk_status_in.sys_stable, clk_status_in.gated_sys_lock};
  property p_nv_read;
    rd_stb_in && addr_in == ADDR_NV_STAT |=> rd_data_out == {4'h0, $past(nv_status_in)};
  endproperty
  a_nv_read: assert property (p_nv_read) else $error("nv status bad");
  property p_clk_read;
    rd_stb_in && addr_in == ADDR_CLK_STAT |=> rd_data_out == $past(clk_exp);
  endproperty
  a_clk_read: assert property (p_clk_read) else $error("clk status bad");
  property p_rsv_read;
    rd_stb_in && addr_in > ADDR_CLK_STAT && addr_in <= ADDR_STAT_LAST |=> rd_data_out == ZERO_BYTE;
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("status range not zero");
  property p_start_cause;
    rom_download_start_out |-> $past(wr_stb_in) && $past(wr_data_in[TRIG_BIT]) &&
      ($past(addr_in) == ADDR_START || $past(addr_in) == ADDR_RESET);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("stray start");
  property p_start_once;
    rom_download_start_out |=> !rom_download_start_out;
  endproperty
  a_start_once: assert property (p_start_once) else $error("start too long");
  property p_soft_reset;
    rom_download_start_out || device_soft_reset_out |->
      device_soft_reset_out == (rom_download_start_out && $past(addr_in) == ADDR_RESET);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset bad");
  property p_cfg_hold;
    !rom_download_start_out |-> $stable(applied_cfg_out);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed");
  property p_bw_map;
    loop_bw_hz_out == (b == BW_1HZ ? BW_VAL_1 : b == BW_10HZ ? BW_VAL_10 :
      b == BW_100HZ ? BW_VAL_100 : BW_VAL_50);
  endproperty
  a_bw_map: assert property (p_bw_map) else $error("bw bad");
  property p_tol_map;
    outer_tol_out == (t == TOL_STRAT3 ? TOL_OUT_STRAT3 : t == TOL_SMC ? TOL_OUT_SMC :
      t == TOL_XTAL ? TOL_OUT_XTAL : TOL_OUT_GENERAL) && inner_tol_out == (t == TOL_STRAT3 ?
      TOL_IN_STRAT3 : t == TOL_SMC ? TOL_IN_SMC : t == TOL_XTAL ? TOL_IN_XTAL : TOL_IN_GENERAL);
  endproperty
  a_tol_map: assert property (p_tol_map) else $error("tol bad");
  c_sreset: cover property (device_soft_reset_out);
  c_clk_rd: cover property (rd_stb_in && addr_in == ADDR_CLK_STAT);
  c_start: cover property (rom_download_start_out ##1 !rom_download_start_out);
endmodule
bind spsr_soft_pin_status spsr_monitor u_mon (.ref_clk_in, .rst_in, .addr_in, .wr_data_in,
  .wr_stb_in, .rd_stb_in, .rd_data_out, .nv_status_in, .clk_status_in, .rom_download_start_out,
  .device_soft_reset_out, .applied_cfg_out, .loop_bw_hz_out, .outer_tol_out, .inner_tol_out);
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) check(nm, e, g)
module testbench;
  import spsr_pkg::*;
  logic ref_clk_in, rst_in, wr_stb_in, rd_stb_in, rom_download_done_in, rd_pend;
  logic rom_download_start_out, device_soft_reset_out;
  logic [ADDR_W-1:0] addr_in, a;
  logic [DATA_W-1:0] wr_data_in, rd_data_out, exp_b, d;
  logic [BW_W-1:0] loop_bw_hz_out;
  logic [TOL_W-1:0] outer_tol_out, inner_tol_out;
  logic [31:0] seed, v;
  spsr_nv_status_type nv_status_in;
  spsr_clk_status_type clk_status_in, c;
  spsr_cfg_type applied_cfg_out, prev;
  int n_fail, check_count;
  logic [DATA_W-1:0] exp_q[$];
  logic [BW_W-1:0] bw_tab[4] = '{BW_VAL_50, BW_VAL_1, BW_VAL_10, BW_VAL_100};
  logic [TOL_W-1:0] out_tab[4] = '{TOL_OUT_GENERAL, TOL_OUT_STRAT3, TOL_OUT_SMC, TOL_OUT_XTAL};
  logic [TOL_W-1:0] in_tab[4] = '{TOL_IN_GENERAL, TOL_IN_STRAT3, TOL_IN_SMC, TOL_IN_XTAL};
  spsr_soft_pin_status DUT (.ref_clk_in, .rst_in, .addr_in, .wr_data_in, .wr_stb_in,
    .rd_stb_in, .rd_data_out, .nv_status_in, .clk_status_in, .rom_download_done_in,
    .rom_download_start_out, .device_soft_reset_out, .applied_cfg_out, .loop_bw_hz_out,
    .outer_tol_out, .inner_tol_out);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
    @(posedge ref_clk_in);
    addr_in <= ad;
    wr_data_in <= dt;
    wr_stb_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_stb_in <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] ex);
    @(posedge ref_clk_in);
    addr_in <= ad;
    rd_stb_in <= 1'b1;
    exp_q.push_back(ex);
    @(posedge ref_clk_in);
    rd_stb_in <= 1'b0;
  endtask
  always @(posedge ref_clk_in) begin
    if (rd_pend) begin
      exp_b = exp_q.pop_front();
      `CHK("rd_data_out", exp_b, rd_data_out);
    end
    rd_pend <= rd_stb_in;
  end
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (3000) @(posedge ref_clk_in);
    n_fail++;
    close_out();
  end
  initial begin
    seed = 66389;
    {wr_stb_in, rd_stb_in, rom_download_done_in} = 3'h0;
    {addr_in, wr_data_in, nv_status_in, clk_status_in} = '0;
    prev = CFG_RESET;
    rst_in = 1'b1;
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    #1 `CHK("bw_default", BW_VAL_50, loop_bw_hz_out);
    `CHK("outer_default", TOL_OUT_GENERAL, outer_tol_out);
    for (int i = 0; i < 8; i++) begin
      v = xs();
      c = v[10:4];
      nv_status_in <= v[3:0];
      clk_status_in <= c;
      wr(v[31] ? ADDR_NV_STAT : ADDR_CLK_STAT, v[23:16]);
      rd(ADDR_NV_STAT, {4'h0, v[3:0]});
      rd(ADDR_CLK_STAT, {c.raw_sys_lock, c.digital_lock & c.analog_lock,
        c.raw_sys_lock & c.digital_lock & c.analog_lock, c.vco_ok, c.cal_busy,
        c.analog_lock, c.sys_stable, c.gated_sys_lock});
    end
    wr(12'hD05, 8'h01);
    rd(ADDR_STAT_LAST, ZERO_BYTE);
    rd(12'h123, ZERO_BYTE);
    for (int i = 0; i < 4; i++) begin
      d = {3'h7, v[i], 2'(i), 2'(3 - i)};
      a = i[0] ? ADDR_RESET : ADDR_START;
      wr(ADDR_LOOP_TOL, d);
      #1 `CHK("cfg_held", prev, applied_cfg_out);
      rd(ADDR_LOOP_TOL, {3'h0, d[4:0]});
      wr(a, 8'hFF);
      #1 `CHK("start", 1'b1, rom_download_start_out);
      `CHK("soft_reset", i[0], device_soft_reset_out);
      `CHK("cfg", d[4:0], applied_cfg_out);
      `CHK("bw", bw_tab[i], loop_bw_hz_out);
      `CHK("outer", out_tab[3 - i], outer_tol_out);
      `CHK("inner", in_tab[3 - i], inner_tol_out);
      rd(a, 8'h01);
      wr(a, 8'h01);
      #1 `CHK("busy_start", 1'b0, rom_download_start_out);
      @(posedge ref_clk_in);
      rom_download_done_in <= 1'b1;
      @(posedge ref_clk_in);
      rom_download_done_in <= 1'b0;
      rd(a, ZERO_BYTE);
      prev = d[4:0];
    end
    wr(ADDR_START, 8'h01);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1 `CHK("bw_reset", BW_VAL_50, loop_bw_hz_out);
    `CHK("inner_reset", TOL_IN_GENERAL, inner_tol_out);
    rd(ADDR_START, ZERO_BYTE);
    repeat (3) @(posedge ref_clk_in);
    close_out();
  end
endmodule
`default_nettype wire
